// file: logic/kwu_pkg.sv
package kwu_pkg;

  // ****************************************
  // Bus geometry
  // ****************************************
  localparam int KWU_DW = 32;
  localparam int KWU_AW = 8;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [KWU_AW-1:0] OFS_U1_CTRL = 8'h00;
  localparam logic [KWU_AW-1:0] OFS_U1_ASSIGN = 8'h04;
  localparam logic [KWU_AW-1:0] OFS_U2_CTRL = 8'h08;
  localparam logic [KWU_AW-1:0] OFS_U2_ASSIGN = 8'h0C;
  localparam logic [KWU_AW-1:0] OFS_U1_PULLUP = 8'h10;
  localparam logic [KWU_AW-1:0] OFS_U2_PULLUP = 8'h14;
  localparam logic [KWU_AW-1:0] OFS_STATUS = 8'h18;
  localparam logic [KWU_AW-1:0] OFS_MASK = 8'h1C;

  // ****************************************
  // Control register fields
  // ****************************************
  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_IE_BIT = 1;
  localparam int CTRL_ACK_BIT = 2;
  localparam int CTRL_FLAG_BIT = 3;
  localparam int CTRL_POL_LSB = 4;
  localparam int CTRL_POL_MSB = 7;

  // ****************************************
  // Unit sizes and event bits
  // ****************************************
  localparam int U1_PINS = 8;
  localparam int U2_PINS = 4;
  localparam int LOWER_PINS = 4;
  localparam int EV_BITS = 2;
  localparam int EV_U1 = 0;
  localparam int EV_U2 = 1;

  typedef enum logic [2:0] {
    KWU_PWR_RUN,
    KWU_PWR_WAIT,
    KWU_PWR_STANDBY,
    KWU_PWR_PARTIAL,
    KWU_PWR_FULL
  } kwu_pwr_type;

endpackage

// file: logic/kwu_top.sv
// ****************************************
// One keypad detection unit
// ****************************************
module kwu_unit #(
  parameter int PINS = 8,
  parameter int LOWER = 4
) (
  input logic clk_i,
  input logic rst_i,
  input logic [PINS-1:0] pin_i,
  input logic [PINS-1:0] assign_i,
  input logic [PINS-1:0] polarity_i,
  input logic edge_level_i,
  input logic ack_i,
  output logic event_o,
  output logic flag_o,
  output logic [PINS-1:0] asserted_o,
  output logic [PINS-1:0] low_o
);
  import kwu_pkg::*;

  typedef struct packed {
    logic [PINS-1:0] sync1;
    logic [PINS-1:0] sync2;
    logic [PINS-1:0] prev;
    logic flag;
    logic event_p;
  } kwu_unit_state_type;

  kwu_unit_state_type q;
  kwu_unit_state_type d;
  logic [PINS-1:0] pol_eff;
  logic [PINS-1:0] level;
  logic [PINS-1:0] edges;

  always_comb begin
    pol_eff = '0;
    for (int i = 0; i < PINS; i++) begin
      if (i >= LOWER) begin
        pol_eff[i] = polarity_i[i];
      end
    end
    d = q;
    // Only sync2 and prev are looked at; sync1 may be metastable
    d.sync1 = pin_i;
    d.sync2 = q.sync1;
    d.prev = q.sync2;
    level = assign_i & (q.sync2 ~^ pol_eff);
    edges = assign_i & ((pol_eff & q.sync2 & ~q.prev)
          | (~pol_eff & ~q.sync2 & q.prev));
    d.event_p = |edges;
    if ((|edges) || (edge_level_i && (|level))) begin
      d.flag = 1'b1;
    end else if (ack_i) begin
      d.flag = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // Idle-high start avoids a false edge out of reset
      q <= '{sync1: '1, sync2: '1, prev: '1, default: '0};
    end else begin
      q <= d;
    end
  end

  assign event_o = q.event_p;
  assign flag_o = q.flag;
  // Raw pins: in stop the clock is gone, so levels are asynchronous
  assign asserted_o = assign_i & (pin_i ~^ pol_eff);
  assign low_o = assign_i & ~pin_i;
endmodule

// ****************************************
// Two units behind a Wishbone slave
// ****************************************
module kwu_top (
  input logic clk_i,
  input logic rst_i,
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic wb_we_i,
  input logic [kwu_pkg::KWU_AW-1:0] wb_adr_i,
  input logic [3:0] wb_sel_i,
  input logic [kwu_pkg::KWU_DW-1:0] wb_dat_i,
  output logic [kwu_pkg::KWU_DW-1:0] wb_dat_o,
  output logic wb_ack_o,
  input logic [kwu_pkg::U1_PINS-1:0] porta_pin_i,
  input logic [kwu_pkg::U1_PINS-1:0] porta_dir_i,
  output logic [kwu_pkg::U1_PINS-1:0] porta_oe_o,
  output logic [kwu_pkg::U1_PINS-1:0] porta_pullup_o,
  output logic [kwu_pkg::U1_PINS-1:0] porta_pulldown_o,
  input logic [kwu_pkg::U2_PINS-1:0] portc_pin_i,
  input logic [kwu_pkg::U2_PINS-1:0] portc_dir_i,
  output logic [kwu_pkg::U2_PINS-1:0] portc_oe_o,
  output logic [kwu_pkg::U2_PINS-1:0] portc_pullup_o,
  input kwu_pkg::kwu_pwr_type power_mode_i,
  output logic wake_o,
  output logic unit1_irq_o,
  output logic unit2_irq_o,
  output logic irq_o
);
  import kwu_pkg::*;

  localparam int UPPER = U1_PINS - LOWER_PINS;

  typedef struct packed {
    logic [U1_PINS-1:0] pe1;
    logic [UPPER-1:0] pol1;
    logic ie1;
    logic mode1;
    logic [U2_PINS-1:0] pe2;
    logic ie2;
    logic mode2;
    logic [U1_PINS-1:0] pu1;
    logic [U2_PINS-1:0] pu2;
    logic [EV_BITS-1:0] status;
    logic [EV_BITS-1:0] mask;
    logic ack;
    logic [KWU_DW-1:0] rdata;
  } kwu_top_state_type;

  kwu_top_state_type q;
  kwu_top_state_type d;

  logic req;
  logic wr;
  logic rd;
  logic ack1;
  logic ack2;
  logic ev1;
  logic ev2;
  logic flag1;
  logic flag2;
  logic [U1_PINS-1:0] pol1_full;
  logic [U1_PINS-1:0] asrt1;
  logic [U1_PINS-1:0] low1;
  logic [U2_PINS-1:0] asrt2;

  // ****************************************
  // Bus decode
  // ****************************************
  // Effects land on the edge where ack is seen high
  assign req = wb_cyc_i & wb_stb_i;
  assign wr = req & q.ack & wb_we_i & wb_sel_i[0];
  assign rd = req & q.ack & ~wb_we_i;
  assign ack1 = wr & (wb_adr_i == OFS_U1_CTRL)
              & wb_dat_i[CTRL_ACK_BIT];
  assign ack2 = wr & (wb_adr_i == OFS_U2_CTRL)
              & wb_dat_i[CTRL_ACK_BIT];
  assign pol1_full = {q.pol1, {LOWER_PINS{1'b0}}};

  // ****************************************
  // Units
  // ****************************************
  kwu_unit #(.PINS(U1_PINS), .LOWER(LOWER_PINS)) u_unit1 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(porta_pin_i),
    .assign_i(q.pe1),
    .polarity_i(pol1_full),
    .edge_level_i(q.mode1),
    .ack_i(ack1),
    .event_o(ev1),
    .flag_o(flag1),
    .asserted_o(asrt1),
    .low_o(low1)
  );

  kwu_unit #(.PINS(U2_PINS), .LOWER(LOWER_PINS)) u_unit2 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(portc_pin_i),
    .assign_i(q.pe2),
    .polarity_i('0),
    .edge_level_i(q.mode2),
    .ack_i(ack2),
    .event_o(ev2),
    .flag_o(flag2),
    .asserted_o(asrt2),
    .low_o()
  );

  // ****************************************
  // Register file
  // ****************************************
  always_comb begin
    d = q;
    d.ack = req & ~q.ack;
    if (req && !q.ack) begin
      d.rdata = '0;
      case (wb_adr_i)
        OFS_U1_CTRL: begin
          d.rdata[CTRL_POL_MSB:CTRL_POL_LSB] = q.pol1;
          d.rdata[CTRL_FLAG_BIT] = flag1;
          d.rdata[CTRL_IE_BIT] = q.ie1;
          d.rdata[CTRL_MODE_BIT] = q.mode1;
        end
        OFS_U2_CTRL: begin
          d.rdata[CTRL_FLAG_BIT] = flag2;
          d.rdata[CTRL_IE_BIT] = q.ie2;
          d.rdata[CTRL_MODE_BIT] = q.mode2;
        end
        OFS_U1_ASSIGN: d.rdata[U1_PINS-1:0] = q.pe1;
        OFS_U2_ASSIGN: d.rdata[U2_PINS-1:0] = q.pe2;
        OFS_U1_PULLUP: d.rdata[U1_PINS-1:0] = q.pu1;
        OFS_U2_PULLUP: d.rdata[U2_PINS-1:0] = q.pu2;
        OFS_STATUS: d.rdata[EV_BITS-1:0] = q.status;
        OFS_MASK: d.rdata[EV_BITS-1:0] = q.mask;
        default: d.rdata = '0;
      endcase
    end
    if (wr) begin
      case (wb_adr_i)
        OFS_U1_CTRL: begin
          d.pol1 = wb_dat_i[CTRL_POL_MSB:CTRL_POL_LSB];
          d.ie1 = wb_dat_i[CTRL_IE_BIT];
          d.mode1 = wb_dat_i[CTRL_MODE_BIT];
        end
        OFS_U2_CTRL: begin
          d.ie2 = wb_dat_i[CTRL_IE_BIT];
          d.mode2 = wb_dat_i[CTRL_MODE_BIT];
        end
        OFS_U1_ASSIGN: d.pe1 = wb_dat_i[U1_PINS-1:0];
        OFS_U2_ASSIGN: d.pe2 = wb_dat_i[U2_PINS-1:0];
        OFS_U1_PULLUP: d.pu1 = wb_dat_i[U1_PINS-1:0];
        OFS_U2_PULLUP: d.pu2 = wb_dat_i[U2_PINS-1:0];
        OFS_MASK: d.mask = wb_dat_i[EV_BITS-1:0];
        default: d.mask = q.mask;
      endcase
    end
    // Set beats the read-clear in the same cycle
    // Clear only the bits returned, so a late event is not lost
    if (rd && (wb_adr_i == OFS_STATUS)) begin
      d.status = q.status & ~q.rdata[EV_BITS-1:0];
    end
    d.status[EV_U1] = d.status[EV_U1] | ev1;
    d.status[EV_U2] = d.status[EV_U2] | ev2;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ****************************************
  // Pads
  // ****************************************
  assign porta_oe_o = porta_dir_i & ~q.pe1;
  assign portc_oe_o = portc_dir_i & ~q.pe2;
  assign porta_pulldown_o = q.pe1 & pol1_full;
  assign porta_pullup_o = q.pu1 & ~porta_oe_o & ~porta_pulldown_o;
  assign portc_pullup_o = q.pu2 & ~portc_oe_o;

  // ****************************************
  // Interrupts and wake
  // ****************************************
  assign unit1_irq_o = flag1 & q.ie1;
  assign unit2_irq_o = flag2 & q.ie2;
  assign irq_o = |(q.status & q.mask);
  assign wb_dat_o = q.rdata;
  assign wb_ack_o = q.ack;

  // Wake is combinational on purpose: no clock runs in stop
  always_comb begin
    unique case (power_mode_i)
      KWU_PWR_RUN: wake_o = 1'b0;
      KWU_PWR_WAIT: wake_o = flag1 | flag2;
      KWU_PWR_STANDBY: wake_o = (|asrt1) | (|asrt2);
      KWU_PWR_PARTIAL: wake_o = |low1;
      KWU_PWR_FULL: wake_o = |low1;
      default: wake_o = 1'b0;
    endcase
  end
endmodule

// file: sim/kwu_keys.sv
// **********
// Switches and interrupt lines at the port pins
// **********
module kwu_keys
  import kwu_pkg::*;
(
  input logic [U1_PINS-1:0] a_press_i,
  input logic [U1_PINS-1:0] a_pulldown_i,
  input logic [U2_PINS-1:0] c_press_i,
  output logic [U1_PINS-1:0] a_pin_o,
  output logic [U2_PINS-1:0] c_pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle lines sit high, or low where the pull-down is on; a switch shorts to the
  // opposite rail of the enabled pull device
  assign a_pin_o = ~(a_press_i ^ a_pulldown_i);
  assign c_pin_o = ~c_press_i;
endmodule

// file: sim/kwu_top_chk.sv
// **********
// Port checks
// **********
module kwu_top_chk
  import kwu_pkg::*;
(
  input logic clk_i,
  input logic rst_i,
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic wb_we_i,
  input logic [KWU_AW-1:0] wb_adr_i,
  input logic [KWU_DW-1:0] wb_dat_o,
  input logic wb_ack_o,
  input logic [U1_PINS-1:0] porta_pin_i,
  input logic [U1_PINS-1:0] porta_dir_i,
  input logic [U1_PINS-1:0] porta_oe_o,
  input logic [U1_PINS-1:0] porta_pullup_o,
  input logic [U1_PINS-1:0] porta_pulldown_o,
  input kwu_pwr_type power_mode_i,
  input logic wake_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ctrl_rd;
    wb_ack_o && !wb_we_i && wb_adr_i == OFS_U1_CTRL;
  endsequence
  chk_ack_next: assert property (s_req |=> wb_ack_o)
    else $error("ack missing after request");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_ack_reads0: assert property (
    s_ctrl_rd |-> wb_dat_o[CTRL_ACK_BIT] == 1'h0)
    else $error("acknowledge bit read back set");
  chk_oe_input: assert property (
    (porta_oe_o & ~porta_dir_i) == 8'h00)
    else $error("output enable without direction");
  chk_pd_lower: assert property (
    porta_pulldown_o[LOWER_PINS-1:0] == 4'h0)
    else $error("pull-down on lower pin");
  chk_pull_excl: assert property (
    (porta_pullup_o & (porta_pulldown_o | porta_oe_o)) == 8'h00)
    else $error("pull-up beside pull-down or output");
  chk_run_nowake: assert property (
    power_mode_i == KWU_PWR_RUN |-> !wake_o)
    else $error("wake while running");
  chk_deep_high: assert property (
    power_mode_i inside {KWU_PWR_PARTIAL, KWU_PWR_FULL} &&
    &porta_pin_i |-> !wake_o)
    else $error("deep wake without low unit-1 pin");
endmodule
bind kwu_top kwu_top_chk u_chk (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_dat_o, .wb_ack_o, .porta_pin_i, .porta_dir_i, .porta_oe_o,
  .porta_pullup_o, .porta_pulldown_o, .power_mode_i, .wake_o
);

// file: sim/kwu_top_tb.sv
`define CHK(g, e) begin \
  samples_checked++; \
  if ((g) !== (e)) begin \
    n_errors++; \
    $display("ERROR t=%0t got %h exp %h", $time, g, e); \
  end \
end
// **********
// Bench
// **********
module kwu_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import kwu_pkg::*;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic wake_o, unit1_irq_o, unit2_irq_o, irq_o;
  logic [KWU_AW-1:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [KWU_DW-1:0] wb_dat_i, wb_dat_o, q;
  logic [U1_PINS-1:0] porta_pin_i, porta_dir_i, porta_oe_o, ka;
  logic [U1_PINS-1:0] porta_pullup_o, porta_pulldown_o;
  logic [U2_PINS-1:0] portc_pin_i, portc_dir_i, portc_oe_o;
  logic [U2_PINS-1:0] portc_pullup_o, kc;
  kwu_pwr_type power_mode_i;
  int n_errors = 0;
  int samples_checked = 0;
  kwu_top dut (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .porta_pin_i,
    .porta_dir_i, .porta_oe_o, .porta_pullup_o, .porta_pulldown_o,
    .portc_pin_i, .portc_dir_i, .portc_oe_o, .portc_pullup_o,
    .power_mode_i, .wake_o, .unit1_irq_o, .unit2_irq_o, .irq_o
  );
  kwu_keys keys (
    .a_press_i(ka), .a_pulldown_i(porta_pulldown_o), .c_press_i(kc),
    .a_pin_o(porta_pin_i), .c_pin_o(portc_pin_i)
  );
  initial begin
    clk_i = 1'h0;
    forever #4 clk_i = ~clk_i;
  end
  task automatic results;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Ends with two idle edges so the write is visible on return
  task automatic bus(input logic we, input logic [KWU_AW-1:0] a,
                     input logic [KWU_DW-1:0] d);
    int n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 20);
    if (n == 20) n_errors++;
    q = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    repeat (2) @(posedge clk_i);
  endtask
  task automatic t_edge;
    bus(1'h0, 8'hFC, 32'h0);
    `CHK(q, 32'h0)
    wb_sel_i <= 4'hE;
    bus(1'h1, OFS_U1_ASSIGN, 32'hFF);
    wb_sel_i <= 4'hF;
    bus(1'h0, OFS_U1_ASSIGN, 32'h0);
    `CHK(q, 32'h0)
    porta_dir_i <= 8'hFF;
    bus(1'h1, OFS_U1_ASSIGN, 32'h01);
    bus(1'h1, OFS_U1_CTRL, 32'h02);
    `CHK(porta_oe_o, 8'hFE)
    ka <= 8'h02;
    repeat (6) @(posedge clk_i);
    `CHK(unit1_irq_o, 1'h0)
    ka <= 8'h01;
    repeat (3) @(posedge clk_i);
    `CHK(unit1_irq_o, 1'h0)
    repeat (3) @(posedge clk_i);
    `CHK(unit1_irq_o, 1'h1)
    bus(1'h0, OFS_U1_CTRL, 32'h0);
    `CHK(q, 32'h0A)
    bus(1'h1, OFS_U1_CTRL, 32'h06);
    `CHK(unit1_irq_o, 1'h0)
    bus(1'h1, OFS_U1_CTRL, 32'h07);
    bus(1'h1, OFS_U1_CTRL, 32'h07);
    `CHK(unit1_irq_o, 1'h1)
    ka <= 8'h00;
    repeat (6) @(posedge clk_i);
    bus(1'h1, OFS_U1_CTRL, 32'h07);
    `CHK(unit1_irq_o, 1'h0)
  endtask
  task automatic t_pol;
    bus(1'h1, OFS_U1_ASSIGN, 32'h11);
    bus(1'h1, OFS_U1_CTRL, 32'hF2);
    `CHK(porta_pulldown_o, 8'h10)
    bus(1'h1, OFS_U1_PULLUP, 32'hFF);
    `CHK(porta_pullup_o, 8'h01)
    repeat (6) @(posedge clk_i);
    ka <= 8'h10;
    repeat (6) @(posedge clk_i);
    `CHK(unit1_irq_o, 1'h1)
    bus(1'h1, OFS_MASK, 32'h02);
    `CHK(irq_o, 1'h0)
    bus(1'h1, OFS_MASK, 32'h01);
    `CHK(irq_o, 1'h1)
    bus(1'h0, OFS_STATUS, 32'h0);
    `CHK(q, 32'h1)
    `CHK(irq_o, 1'h0)
    ka <= 8'h00;
    repeat (6) @(posedge clk_i);
  endtask
  // Deep stops only see raw unit-1 pins, so flags are cleared first
  task automatic t_wake;
    bus(1'h1, OFS_U1_CTRL, 32'h06);
    portc_dir_i <= 4'hF;
    bus(1'h1, OFS_U2_ASSIGN, 32'h01);
    bus(1'h1, OFS_U2_CTRL, 32'h02);
    `CHK(portc_oe_o, 4'hE)
    bus(1'h1, OFS_U2_PULLUP, 32'h0F);
    `CHK(portc_pullup_o, 4'h1)
    kc <= 4'h1;
    repeat (6) @(posedge clk_i);
    `CHK(unit2_irq_o, 1'h1)
    power_mode_i <= KWU_PWR_WAIT;
    @(posedge clk_i);
    `CHK(wake_o, 1'h1)
    bus(1'h1, OFS_U2_CTRL, 32'h06);
    power_mode_i <= KWU_PWR_STANDBY;
    @(posedge clk_i);
    `CHK(wake_o, 1'h1)
    power_mode_i <= KWU_PWR_PARTIAL;
    @(posedge clk_i);
    `CHK(wake_o, 1'h0)
    ka <= 8'h10;
    @(posedge clk_i);
    `CHK(wake_o, 1'h1)
    power_mode_i <= KWU_PWR_FULL;
    @(posedge clk_i);
    `CHK(wake_o, 1'h1)
    power_mode_i <= KWU_PWR_RUN;
  endtask
  initial begin
    rst_i = 1'h1;
    wb_cyc_i = 1'h0;
    wb_stb_i = 1'h0;
    wb_we_i = 1'h0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    porta_dir_i = 8'h00;
    portc_dir_i = 4'h0;
    ka = 8'h00;
    kc = 4'h0;
    power_mode_i = KWU_PWR_RUN;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'h0;
    t_edge();
    t_pol();
    t_wake();
    results();
  end
  initial begin
    repeat (5000) @(posedge clk_i);
    n_errors++;
    results();
  end
endmodule
